//--- src/tpwm_pkg.sv
// constants shared by the six-channel timer pwm block
// assumes an 8-bit register port and one bus clock domain
package tpwm_pkg;
  localparam int unsigned NUM_CH = 6;
  localparam int unsigned NUM_PAIR = 3;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PRESC_W = 6;
  // register offsets
  localparam logic [4:0] OFF_STATUS = 5'h00;
  localparam logic [4:0] OFF_CNT_HI = 5'h01;
  localparam logic [4:0] OFF_CNT_LO = 5'h02;
  localparam logic [4:0] OFF_PER_HI = 5'h03;
  localparam logic [4:0] OFF_PER_LO = 5'h04;
  localparam logic [4:0] OFF_CH_BASE = 5'h05;
  localparam logic [4:0] CH_STRIDE = 5'h03;
  localparam logic [4:0] CH_SPAN = 5'h12;
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_HI = 2'h1;
  localparam logic [1:0] SEL_LO = 2'h2;
  // timer_status_control fields
  localparam int unsigned SC_OVF_FLAG = 7;
  localparam int unsigned SC_OVF_IE = 6;
  localparam int unsigned SC_HALT = 5;
  localparam int unsigned SC_CLEAR = 4;
  localparam int unsigned SC_DIV_HI = 2;
  // channel_status_control fields
  localparam int unsigned CS_FLAG = 7;
  localparam int unsigned CS_IE = 6;
  localparam int unsigned CS_LINK = 5;
  localparam int unsigned CS_SINGLE = 4;
  localparam int unsigned CS_ELS_HI = 3;
  localparam int unsigned CS_ELS_LO = 2;
  localparam int unsigned CS_TOV = 1;
  localparam int unsigned CS_FULL = 0;
  // reset values
  localparam logic [15:0] PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] VALUE_RST = 16'h0000;
  localparam logic HALT_RST = 1'b1;
  localparam logic [2:0] DIV_RST = 3'h0;
  // encodings
  localparam logic [2:0] DIV_EXT = 3'h7;
  localparam logic [1:0] ELS_TOGGLE = 2'h1;
  localparam logic [1:0] ELS_CLEAR = 2'h2;
  localparam logic [1:0] ELS_SET = 2'h3;
endpackage : tpwm_pkg

//--- src/tpwm_pin_if.sv
// per-channel link between the timer core and one pin output unit
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface tpwm_pin_if;
  logic active;
  logic ovf_event;
  logic match_event;
  logic toggle_en;
  logic full_duty;
  logic [1:0] els;
  logic pin;
  modport ctl (output active, output ovf_event, output match_event, output toggle_en, output full_duty,
    output els, input pin);
  modport unit (input active, input ovf_event, input match_event, input toggle_en, input full_duty,
    input els, output pin);
endinterface : tpwm_pin_if

//--- src/tpwm_pin_unit.sv
// output level logic of one timer channel pin
// assumes events are single-cycle pulses from the timer core
`timescale 1ns/10ps
module tpwm_pin_unit (
  input wire logic clk,
  input wire logic srst,
  tpwm_pin_if.unit p
);
  logic pin_q;
  logic next_pin;
  wire logic full_on = p.full_duty & p.toggle_en;
  wire logic cmp_level = (p.els == tpwm_pkg::ELS_CLEAR) ? 1'b0 :
                         (p.els == tpwm_pkg::ELS_SET) ? 1'b1 :
                         (p.els == tpwm_pkg::ELS_TOGGLE) ? ~pin_q : pin_q; // [R13]
  // compare wins over a same-cycle overflow so a zero compare gives 0% duty
  assign next_pin = !p.active ? pin_q :
                    full_on ? ~p.els[0] : // [R15]
                    p.match_event ? cmp_level : // [R2]
                    (p.ovf_event & p.toggle_en) ? ~pin_q : pin_q; // [R1] [R14]
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= next_pin;
    end
  end
  assign p.pin = pin_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_full_duty_level: assert property (p.active && full_on |=> pin_q == ~$past(p.els[0])) // [R15]
    else $error("full duty level wrong");
  chk_zero_duty_hold: assert property (p.active && !p.toggle_en && !p.full_duty && !pin_q
    && p.els == tpwm_pkg::ELS_CLEAR |=> !pin_q) // [R14]
    else $error("zero duty output moved");
  chk_ovf_toggle: assert property (p.active && p.ovf_event && p.toggle_en && !p.match_event && !p.full_duty
    |=> pin_q != $past(pin_q)) // [R1]
    else $error("overflow toggle missing");
  cover property (p.active && p.match_event && p.els == tpwm_pkg::ELS_CLEAR ##1 !pin_q);
endmodule : tpwm_pin_unit

//--- src/tpwm_timer.sv
// six-channel 16-bit timer with pwm outputs and byte register port
// assumes strobes and mode inputs come from logic on clk; ext clock pin is async
//
// Function
// R1 - overflow toggles pin when toggle enabled
// R2 - width runs from overflow to compare
// R3 - period equals modulo plus one clocks
// R4 - duty equals compare over period count
// R5 - unbuffered value writes take effect immediately
// R6 - software times unbuffered width changes
// R7 - software avoids toggle-on-compare for pwm
// R8 - link bit pairs even with odd channel
// R9 - last written pair governs after overflow
// R10 - software writes only the inactive pair
// R11 - software follows the pwm init sequence
// R12 - mode field selects unbuffered or buffered
// R13 - edge/level field clears or sets on compare
// R14 - toggle disabled gives constant zero duty
// R15 - full duty bit gives constant full duty
// R16 - overflow flag gated by overflow irq enable; the flag sets on every overflow outside a pending modulo write, overflow_irq and wake_request are gated
// R17 - per-channel event flag and irq enable
// R18 - wait mode keeps running, blocks register access
// R19 - stop mode freezes counter and registers
// R20 - wrap to zero; high modulo write inhibits flag
// R21 - divider select picks prescale or external clock
// R22 - clear bit zeroes counter and prescaler
// R23 - one shared counter advances per timer clock
`timescale 1ns/10ps
module tpwm_timer (
  input wire logic clk,
  input wire logic srst,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic ext_timer_clk,
  input wire logic wait_mode,
  input wire logic stop_mode,
  output logic [5:0] channel_pin_out,
  output logic [5:0] channel_pin_oe,
  output logic overflow_irq,
  output logic [5:0] channel_irq,
  output logic wake_request
);
  localparam int unsigned N = tpwm_pkg::NUM_CH;

  // register index decode for channel space: {hit, channel, field}
  function automatic logic [5:0] tpwm_ch_decode(input logic [4:0] a);
    logic [4:0] idx;
    logic hit;
    idx = a - tpwm_pkg::OFF_CH_BASE;
    hit = (a >= tpwm_pkg::OFF_CH_BASE) && (idx < tpwm_pkg::CH_SPAN);
    return {hit, 3'(idx / tpwm_pkg::CH_STRIDE), 2'(idx % tpwm_pkg::CH_STRIDE)};
  endfunction : tpwm_ch_decode

  // prescaler tap: divide by 2**sel
  function automatic logic tpwm_div_tick(input logic [5:0] pre, input logic [2:0] sel);
    logic [6:0] m;
    m = (7'h01 << sel) - 7'h01;
    return (pre & m[5:0]) == m[5:0];
  endfunction : tpwm_div_tick

  // status and counter state
  logic ovf_flag;
  logic ovf_ie;
  logic halt;
  logic [2:0] div_sel;
  logic ovf_armed;
  logic [15:0] count;
  logic [5:0] presc;
  logic [15:0] period;
  logic period_pending;
  logic [7:0] cnt_lo_latch;
  logic cnt_latched;
  logic [2:0] ext_sync;
  // channel state
  logic [N-1:0] ch_flag;
  logic [N-1:0] ch_armed;
  logic [N-1:0] ch_ie;
  logic [N-1:0] link;
  logic [N-1:0] single;
  logic [N-1:0] tov;
  logic [N-1:0] full;
  logic [1:0] els [N];
  logic [15:0] value [N];
  logic [2:0] act_odd;
  logic [2:0] pend_odd;
  logic [7:0] next_rdata;

  // bus decode; wait mode cuts processor access but not counting
  wire logic bus_ok = ~wait_mode & ~stop_mode; // [R18]
  wire logic wr_en = bus_wr & bus_ok;
  wire logic rd_en = bus_rd & bus_ok;
  wire logic [5:0] wr_dec = tpwm_ch_decode(bus_addr);
  wire logic ch_hit = wr_dec[5];
  wire logic [2:0] acc_ch = wr_dec[4:2];
  wire logic [1:0] acc_sel = wr_dec[1:0];
  wire logic wr_status = wr_en & (bus_addr == tpwm_pkg::OFF_STATUS);
  wire logic rd_status = rd_en & (bus_addr == tpwm_pkg::OFF_STATUS);
  wire logic wr_per_hi = wr_en & (bus_addr == tpwm_pkg::OFF_PER_HI);
  wire logic wr_per_lo = wr_en & (bus_addr == tpwm_pkg::OFF_PER_LO);
  wire logic rd_cnt_hi = rd_en & (bus_addr == tpwm_pkg::OFF_CNT_HI);
  wire logic rd_cnt_lo = rd_en & (bus_addr == tpwm_pkg::OFF_CNT_LO);
  wire logic wr_ch = wr_en & ch_hit;
  wire logic rd_ch = rd_en & ch_hit;
  wire logic clear_req = wr_status & bus_wdata[tpwm_pkg::SC_CLEAR]; // [R22]

  // timer clock: external pin through two flops, edge taken past them
  wire logic ext_edge = ext_sync[1] & ~ext_sync[2];
  wire logic run = ~halt & ~stop_mode; // [R19]
  wire logic tick = run & ((div_sel == tpwm_pkg::DIV_EXT) ? ext_edge : tpwm_div_tick(presc, div_sel)); // [R21]
  wire logic wrap = tick & (count == period); // [R3] [R20]
  wire logic [15:0] cnt_adv = wrap ? 16'h0000 : count + 16'h0001; // [R23]
  wire logic ovf_event = wrap & ~period_pending; // [R20]

  // per-channel compare against the shared counter
  logic [15:0] eff_val [N];
  logic [N-1:0] drives;
  logic [N-1:0] match;
  logic [N-1:0] wr_value;
  for (genvar c = 0; c < N; c++) begin : g_cmp
    if (c % 2 == 0) begin : g_even
      assign eff_val[c] = (link[c] && act_odd[c/2]) ? value[c+1] : value[c]; // [R9]
      assign drives[c] = link[c] | single[c]; // [R12]
    end else begin : g_odd
      assign eff_val[c] = value[c];
      assign drives[c] = ~link[c-1] & ~link[c] & single[c]; // [R8] [R12]
    end
    // value equals count of high clocks, so duty is value over period+1
    assign match[c] = tick & drives[c] & (cnt_adv == eff_val[c]); // [R2] [R4]
    assign wr_value[c] = wr_ch & (acc_ch == 3'(c)) & (acc_sel != tpwm_pkg::SEL_CTRL);
  end

  // status register and counter
  always_ff @(posedge clk) begin
    if (srst) begin
      ovf_flag <= 1'b0;
      ovf_ie <= 1'b0;
      halt <= tpwm_pkg::HALT_RST;
      div_sel <= tpwm_pkg::DIV_RST;
      ovf_armed <= 1'b0;
      count <= 16'h0000;
      presc <= 6'h00;
      ext_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_timer_clk};
      if (wr_status) begin
        ovf_ie <= bus_wdata[tpwm_pkg::SC_OVF_IE];
        halt <= bus_wdata[tpwm_pkg::SC_HALT];
        div_sel <= bus_wdata[tpwm_pkg::SC_DIV_HI:0];
      end
      // a new overflow beats a clear in the same cycle
      if (ovf_event) begin
        ovf_flag <= 1'b1; // [R16]
      end else if (wr_status && ovf_armed && !bus_wdata[tpwm_pkg::SC_OVF_FLAG]) begin
        ovf_flag <= 1'b0;
      end
      if (ovf_event || wr_status) begin
        ovf_armed <= 1'b0;
      end else if (rd_status && ovf_flag) begin
        ovf_armed <= 1'b1;
      end
      if (clear_req) begin
        count <= 16'h0000; // [R22]
        presc <= 6'h00;
      end else begin
        presc <= run ? presc + 6'h01 : presc;
        count <= tick ? cnt_adv : count; // [R23]
      end
    end
  end

  // modulo and counter read latch; high byte write holds off the flag
  always_ff @(posedge clk) begin
    if (srst) begin
      period <= tpwm_pkg::PERIOD_RST;
      period_pending <= 1'b0;
      cnt_lo_latch <= 8'h00;
      cnt_latched <= 1'b0;
    end else begin
      if (wr_per_hi) begin
        period[15:8] <= bus_wdata;
        period_pending <= 1'b1; // [R20]
      end
      if (wr_per_lo) begin
        period[7:0] <= bus_wdata;
        period_pending <= 1'b0;
      end
      if (rd_cnt_hi && !cnt_latched) begin
        cnt_lo_latch <= count[7:0];
        cnt_latched <= 1'b1;
      end else if (rd_cnt_lo) begin
        cnt_latched <= 1'b0;
      end
    end
  end

  // channel control, value and flag registers
  always_ff @(posedge clk) begin
    if (srst) begin
      ch_flag <= '0;
      ch_armed <= '0;
      ch_ie <= '0;
      link <= '0;
      single <= '0;
      tov <= '0;
      full <= '0;
      for (int c = 0; c < N; c++) begin
        els[c] <= 2'h0;
        value[c] <= tpwm_pkg::VALUE_RST;
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        if (wr_ch && acc_ch == 3'(c) && acc_sel == tpwm_pkg::SEL_CTRL) begin
          ch_ie[c] <= bus_wdata[tpwm_pkg::CS_IE];
          link[c] <= (c % 2 == 0) ? bus_wdata[tpwm_pkg::CS_LINK] : 1'b0; // [R8]
          single[c] <= bus_wdata[tpwm_pkg::CS_SINGLE];
          els[c] <= bus_wdata[tpwm_pkg::CS_ELS_HI:tpwm_pkg::CS_ELS_LO]; // [R13]
          tov[c] <= bus_wdata[tpwm_pkg::CS_TOV];
          full[c] <= bus_wdata[tpwm_pkg::CS_FULL];
        end
        // writes land at once; a passed compare is simply missed this period
        if (wr_value[c] && acc_sel == tpwm_pkg::SEL_HI) begin
          value[c][15:8] <= bus_wdata; // [R5]
        end
        if (wr_value[c] && acc_sel == tpwm_pkg::SEL_LO) begin
          value[c][7:0] <= bus_wdata; // [R5]
        end
        if (match[c]) begin
          ch_flag[c] <= 1'b1; // [R17]
        end else if (wr_ch && acc_ch == 3'(c) && acc_sel == tpwm_pkg::SEL_CTRL && ch_armed[c]
                     && !bus_wdata[tpwm_pkg::CS_FLAG]) begin
          ch_flag[c] <= 1'b0;
        end
        if (match[c] || (wr_ch && acc_ch == 3'(c) && acc_sel == tpwm_pkg::SEL_CTRL)) begin
          ch_armed[c] <= 1'b0;
        end else if (rd_ch && acc_ch == 3'(c) && acc_sel == tpwm_pkg::SEL_CTRL && ch_flag[c]) begin
          ch_armed[c] <= 1'b1;
        end
      end
    end
  end

  // buffered pairs: last written half takes over at each overflow
  always_ff @(posedge clk) begin
    if (srst) begin
      act_odd <= 3'h0;
      pend_odd <= 3'h0;
    end else begin
      for (int p = 0; p < tpwm_pkg::NUM_PAIR; p++) begin
        if (!link[2*p]) begin
          act_odd[p] <= 1'b0; // [R9]
          pend_odd[p] <= 1'b0;
        end else begin
          if (wr_value[2*p+1]) begin
            pend_odd[p] <= 1'b1; // [R9]
          end else if (wr_value[2*p]) begin
            pend_odd[p] <= 1'b0;
          end
          if (wrap) begin
            act_odd[p] <= pend_odd[p]; // [R9]
          end
        end
      end
    end
  end

  // read data, valid only in the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (rd_status) begin
      next_rdata = {ovf_flag, ovf_ie, halt, 2'b00, div_sel}; // [R22]
    end else if (rd_cnt_hi) begin
      next_rdata = count[15:8];
    end else if (rd_cnt_lo) begin
      next_rdata = cnt_latched ? cnt_lo_latch : count[7:0];
    end else if (rd_en && bus_addr == tpwm_pkg::OFF_PER_HI) begin
      next_rdata = period[15:8];
    end else if (rd_en && bus_addr == tpwm_pkg::OFF_PER_LO) begin
      next_rdata = period[7:0];
    end else if (rd_ch && acc_sel == tpwm_pkg::SEL_CTRL) begin
      next_rdata = {ch_flag[acc_ch], ch_ie[acc_ch], link[acc_ch], single[acc_ch], els[acc_ch],
                    tov[acc_ch], full[acc_ch]};
    end else if (rd_ch && acc_sel == tpwm_pkg::SEL_HI) begin
      next_rdata = value[acc_ch][15:8];
    end else if (rd_ch) begin
      next_rdata = value[acc_ch][7:0];
    end
  end

  // registered outputs
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_rdata <= 8'h00;
      overflow_irq <= 1'b0;
      channel_irq <= '0;
      channel_pin_oe <= '0;
      wake_request <= 1'b0;
    end else begin
      bus_rdata <= next_rdata;
      overflow_irq <= ovf_flag & ovf_ie; // [R16]
      channel_irq <= ch_flag & ch_ie; // [R17]
      channel_pin_oe <= drives; // [R8]
      wake_request <= wait_mode & ((ovf_flag & ovf_ie) | (|(ch_flag & ch_ie))); // [R18]
    end
  end

  // pin units; odd half of a pair stays idle so its pin is free
  for (genvar c = 0; c < N; c++) begin : g_pin
    tpwm_pin_if pif ();
    assign pif.active = drives[c];
    assign pif.ovf_event = wrap; // [R1]
    assign pif.match_event = match[c];
    assign pif.toggle_en = tov[c]; // [R14]
    assign pif.full_duty = full[c]; // [R15]
    assign pif.els = els[c];
    assign channel_pin_out[c] = pif.pin;
    tpwm_pin_unit u_pin (
      .clk(clk),
      .srst(srst),
      .p(pif)
    );
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_wrap_to_zero: assert property (wrap |=> count == 16'h0000) // [R20]
    else $error("counter did not restart at zero");
  chk_ovf_flag_set: assert property (ovf_event |=> ovf_flag) // [R16]
    else $error("overflow flag not set");
  chk_irq_gated: assert property (ovf_flag && !ovf_ie |=> !overflow_irq) // [R16]
    else $error("overflow irq while disabled");
  chk_stop_freeze: assert property (stop_mode && !clear_req |=> count == $past(count)) // [R19]
    else $error("counter moved in stop mode");
  chk_clear_zero: assert property (clear_req |=> count == 16'h0000 && presc == 6'h00) // [R22]
    else $error("clear did not zero counter");
  chk_count_step: assert property (tick && !wrap && !clear_req |=> count == $past(count) + 16'h0001) // [R23]
    else $error("counter step wrong");
  chk_hold_flag: assert property (wrap && period_pending && !ovf_flag |=> !ovf_flag) // [R20]
    else $error("flag set during modulo update");
  chk_wait_no_write: assert property (wait_mode && bus_wr && bus_addr == tpwm_pkg::OFF_STATUS
    |=> ovf_ie == $past(ovf_ie)) // [R18]
    else $error("register written in wait mode");
  chk_link_odd_off: assert property (link[0] |=> !channel_pin_oe[1]) // [R8]
    else $error("odd pin driven while linked");
  chk_pair_swap: assert property (wrap && link[0] |=> act_odd[0] == $past(pend_odd[0])) // [R9]
    else $error("buffered pair did not switch");
  chk_flag_on_match: assert property (match[0] |=> ch_flag[0] ##1 channel_irq[0] == $past(ch_ie[0])) // [R17]
    else $error("channel flag not set on compare");
  cover property (ovf_event && ovf_ie ##2 overflow_irq);
  cover property (link[0] && wrap && pend_odd[0] && !act_odd[0]);
  cover property (wait_mode && wake_request);
endmodule : tpwm_timer

//--- sim/tpwm_load.sv
// load model on the six pwm pins: counts high cycles per line over a window
// assumes the pins and the bench share clk; an undriven pin sits at a pull-down
`timescale 1ns/10ps
module tpwm_load (
  input wire logic clk,
  input wire logic [5:0] pin_out,
  input wire logic [5:0] pin_oe,
  input wire logic start,
  input wire logic [9:0] win,
  output logic busy,
  output logic [5:0][9:0] high_cnt
);
  logic [5:0] line;
  logic [9:0] left = 10'h000;
  // released pins fall to the pull-down level, never the last driven value
  assign line = pin_out & pin_oe;
  assign busy = (left != 10'h000);
  always_ff @(posedge clk) begin
    if (start) begin
      left <= win;
      high_cnt <= '0;
    end else if (busy) begin
      left <= left - 10'h001;
      for (int i = 0; i < 6; i++) begin
        high_cnt[i] <= high_cnt[i] + {9'h000, line[i]};
      end
    end
  end
endmodule : tpwm_load

//--- sim/tpwm_timer_tb.sv
// self-checking bench for the six-channel pwm timer
// assumes a 40 MHz clk, synchronous reset and the byte register map of the package
`timescale 1ns/10ps
module tpwm_timer_tb;
  logic clk, srst, bus_wr, bus_rd, ext_timer_clk, wait_mode, stop_mode, ld_start, ld_busy, lvl;
  logic [4:0] bus_addr;
  logic [7:0] bus_wdata, bus_rdata, rd_val;
  logic ext_run;
  logic [5:0] channel_pin_out, channel_pin_oe, channel_irq;
  logic overflow_irq, wake_request;
  logic [9:0] ld_win;
  logic [5:0][9:0] high_cnt;
  int bad_count, checks_done;
  logic [7:0] lo_val [5] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h40};
  logic [7:0] ctl_val [5] = '{8'h1A, 8'h18, 8'h1B, 8'h1E, 8'h2A};
  logic [9:0] exp_hi [6] = '{10'h080, 10'h000, 10'h100, 10'h0C0, 10'h040, 10'h000};

  tpwm_timer i_tpwm_timer (.clk(clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .ext_timer_clk(ext_timer_clk),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .channel_pin_out(channel_pin_out),
    .channel_pin_oe(channel_pin_oe), .overflow_irq(overflow_irq), .channel_irq(channel_irq),
    .wake_request(wake_request));
  tpwm_load i_tpwm_load (.clk(clk), .pin_out(channel_pin_out), .pin_oe(channel_pin_oe),
    .start(ld_start), .win(ld_win), .busy(ld_busy), .high_cnt(high_cnt));

  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // external timer clock: one rising edge every two bus clocks while enabled
  always @(posedge clk) begin
    ext_timer_clk <= ext_run ? ~ext_timer_clk : 1'h0;
  end

  function automatic logic [4:0] caddr(input int c, input logic [1:0] s);
    return tpwm_pkg::OFF_CH_BASE + 5'(c) * tpwm_pkg::CH_STRIDE + {3'h0, s};
  endfunction : caddr

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'h1;
    @(posedge clk);
    bus_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    bus_addr <= a;
    bus_rd <= 1'h1;
    @(posedge clk);
    bus_rd <= 1'h0;
    #1 rd_val = bus_rdata;
  endtask : rd

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // window length in clocks; alignment to the period does not matter
  task automatic measure(input logic [9:0] w);
    @(posedge clk);
    ld_win <= w;
    ld_start <= 1'h1;
    @(posedge clk);
    ld_start <= 1'h0;
    repeat (2) @(posedge clk);
    repeat (1100) if (ld_busy === 1'h1) @(posedge clk);
  endtask : measure

  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    finish_test();
  end

  initial begin
    srst = 1'h1;
    bus_addr = 5'h00;
    bus_wdata = 8'h00;
    bus_wr = 1'h0;
    bus_rd = 1'h0;
    ext_run = 1'h0;
    wait_mode = 1'h0;
    stop_mode = 1'h0;
    ld_start = 1'h0;
    ld_win = 10'h100;
    bad_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    rd(tpwm_pkg::OFF_STATUS);
    chk("status reset", 16'h0020, {8'h00, rd_val});
    rd(tpwm_pkg::OFF_PER_LO);
    chk("period reset", 16'h00FF, {8'h00, rd_val});
    rd(5'h1F);
    chk("unmapped read", 16'h0000, {8'h00, rd_val});
    // halt and clear, period, widths, modes, then release
    wr(tpwm_pkg::OFF_STATUS, 8'h30);
    wr(tpwm_pkg::OFF_PER_HI, 8'h00);
    wr(tpwm_pkg::OFF_PER_LO, 8'hFF);
    for (int c = 0; c < 5; c++) begin
      wr(caddr(c, tpwm_pkg::SEL_HI), 8'h00);
      wr(caddr(c, tpwm_pkg::SEL_LO), lo_val[c]);
      wr(caddr(c, tpwm_pkg::SEL_CTRL), ctl_val[c]);
    end
    wr(caddr(5, tpwm_pkg::SEL_CTRL), 8'h1A);
    wr(tpwm_pkg::OFF_STATUS, 8'h00);
    repeat (600) @(posedge clk);
    measure(10'h100);
    for (int c = 0; c < 6; c++) begin
      chk("high count", {6'h00, exp_hi[c]}, {6'h00, high_cnt[c]});
    end
    chk("pin enables", 16'h001F, {10'h000, channel_pin_oe});
    // new width goes to the inactive odd register only
    wr(caddr(5, tpwm_pkg::SEL_HI), 8'h00);
    wr(caddr(5, tpwm_pkg::SEL_LO), 8'hC0);
    repeat (600) @(posedge clk);
    measure(10'h100);
    chk("linked odd width", 16'h00C0, {6'h00, high_cnt[4]});
    wr(caddr(4, tpwm_pkg::SEL_LO), 8'h20);
    wr(caddr(0, tpwm_pkg::SEL_LO), 8'h40);
    repeat (600) @(posedge clk);
    measure(10'h100);
    chk("linked even width", 16'h0020, {6'h00, high_cnt[4]});
    chk("unbuffered width", 16'h0040, {6'h00, high_cnt[0]});
    rd(tpwm_pkg::OFF_STATUS);
    chk("overflow flag", 16'h0080, {8'h00, rd_val});
    chk("overflow irq off", 16'h0000, {15'h0000, overflow_irq});
    wr(tpwm_pkg::OFF_STATUS, 8'h40);
    repeat (300) @(posedge clk);
    chk("overflow irq on", 16'h0001, {15'h0000, overflow_irq});
    rd(caddr(0, tpwm_pkg::SEL_CTRL));
    chk("channel flag", 16'h009A, {8'h00, rd_val});
    chk("channel irq off", 16'h0000, {10'h000, channel_irq});
    wr(caddr(0, tpwm_pkg::SEL_CTRL), 8'h5A);
    repeat (300) @(posedge clk);
    chk("channel irq on", 16'h0001, {10'h000, channel_irq});
    wait_mode <= 1'h1;
    repeat (5) @(posedge clk);
    chk("wake request", 16'h0001, {15'h0000, wake_request});
    rd(tpwm_pkg::OFF_STATUS);
    chk("read in wait", 16'h0000, {8'h00, rd_val});
    measure(10'h100);
    chk("width in wait", 16'h0040, {6'h00, high_cnt[0]});
    wait_mode <= 1'h0;
    stop_mode <= 1'h1;
    repeat (3) @(posedge clk);
    lvl = channel_pin_out[0];
    measure(10'h100);
    chk("frozen pin", lvl ? 16'h0100 : 16'h0000, {6'h00, high_cnt[0]});
    stop_mode <= 1'h0;
    repeat (600) @(posedge clk);
    measure(10'h100);
    chk("width after stop", 16'h0040, {6'h00, high_cnt[0]});
    // halt plus clear parks the counter at zero, divide by two selected
    wr(tpwm_pkg::OFF_STATUS, 8'h31);
    rd(tpwm_pkg::OFF_CNT_HI);
    chk("counter hi cleared", 16'h0000, {8'h00, rd_val});
    rd(tpwm_pkg::OFF_CNT_LO);
    chk("counter lo cleared", 16'h0000, {8'h00, rd_val});
    wr(tpwm_pkg::OFF_STATUS, 8'h01);
    repeat (1200) @(posedge clk);
    measure(10'h200);
    chk("width divided", 16'h0080, {6'h00, high_cnt[0]});
    // pin clock at half the bus rate gives the same width as divide by two
    ext_run <= 1'h1;
    wr(tpwm_pkg::OFF_STATUS, 8'h07);
    repeat (1200) @(posedge clk);
    measure(10'h200);
    chk("width external", 16'h0080, {6'h00, high_cnt[0]});
    // high modulo byte alone holds the flag off over several wraps
    wr(tpwm_pkg::OFF_PER_HI, 8'h00);
    rd(tpwm_pkg::OFF_STATUS);
    wr(tpwm_pkg::OFF_STATUS, 8'h07);
    repeat (1200) @(posedge clk);
    rd(tpwm_pkg::OFF_STATUS);
    chk("flag held off", 16'h0007, {8'h00, rd_val});
    wr(tpwm_pkg::OFF_PER_LO, 8'hFF);
    repeat (600) @(posedge clk);
    rd(tpwm_pkg::OFF_STATUS);
    chk("flag after modulo", 16'h0087, {8'h00, rd_val});
    finish_test();
  end
endmodule : tpwm_timer_tb
